/* tlw_device.sv */
`timescale 1ns/10ps
module tlw_device
  import tlw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  devAddrStrap,
  input  wire pull_mode_e  modeStrap,
  tlw_if.device_mp         link,
  output logic [PULL_W-1:0] pullValue,
  output logic             pullUpdate,
  output logic             settling,
  output logic             linkReady
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  localparam logic [4:0]  BODY_LAST   = 5'(FRAME_BITS - HDR_BITS - 1);
  localparam logic [9:0]  POWERUP_END = 10'(POWERUP_CYC - 1);
  localparam logic [11:0] SETTLE_LEN  = 12'(SETTLE_CYC);

  typedef struct packed {
    level_e            sync1;
    level_e            sync2;
    level_e            sync3;
    level_e            level;
    logic              armed;
    logic              bitVal;
    logic [39:0]       shift;
    logic              inFrame;
    logic [4:0]        count;
    logic [15:0]       lowerWord;
    logic [15:0]       upperWord;
    logic [PULL_W-1:0] pull;
    logic              update;
    logic [11:0]       settle;
    logic [9:0]        powerCnt;
    logic              ready;
    pull_mode_e        mode;
    logic [3:0]        addr;
  } dev_s;

  dev_s st_r;
  dev_s st_nxt;

  function automatic logic headerMatch(input logic [15:0] h);
    headerMatch = (h[15:8] == HDR_HI) && (h[3:0] == HDR_LO);
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic        gotBit;
    logic [39:0] sh;
    gotBit = 1'b0;
    sh     = st_r.shift;
    st_nxt = st_r;
    st_nxt.update = 1'b0;

    // three-stage pin synchroniser, level taken when stages two and three agree
    st_nxt.sync1 = link.lineLevel;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    if (st_r.sync2 == st_r.sync3)
    begin
      st_nxt.level = st_r.sync2;
    end

    // power-up delay, straps caught once it ends
    if (!st_r.ready)
    begin
      st_nxt.powerCnt = st_r.powerCnt + 10'h1;
      if (st_r.powerCnt == POWERUP_END)
      begin
        st_nxt.ready = 1'b1;
        st_nxt.mode  = modeStrap;
        st_nxt.addr  = devAddrStrap;
      end
    end

    if (st_r.settle != 12'h0)
    begin
      st_nxt.settle = st_r.settle - 12'h1;
    end

    // bit decode on settled level changes
    if (st_r.ready && st_nxt.level != st_r.level)
    begin
      case (st_nxt.level)
        LVL_HIGH:
        begin
          st_nxt.armed  = 1'b1;
          st_nxt.bitVal = 1'b1;
        end
        LVL_LOW:
        begin
          st_nxt.armed  = 1'b1;
          st_nxt.bitVal = 1'b0;
        end
        LVL_MID:
        begin
          gotBit       = st_r.armed; // mid completes the bit
          st_nxt.armed = 1'b0;
        end
        default: st_nxt.armed = 1'b0;
      endcase
    end

    // frame assembly
    if (gotBit)
    begin
      sh = {st_r.shift[38:0], st_r.bitVal}; // msb first
      st_nxt.shift = sh;
      if (!st_r.inFrame)
      begin
        if (headerMatch(sh[15:0]))
        begin
          st_nxt.inFrame = 1'b1;
          st_nxt.count   = 5'h0;
        end
      end
      else if (st_r.count != BODY_LAST)
      begin
        st_nxt.count = st_r.count + 5'h1;
      end
      else
      begin
        // 16 header + 8 address + 16 data bits complete
        st_nxt.inFrame = 1'b0;
        st_nxt.shift   = 40'h0;
        if (sh[31:28] == st_r.addr) // foreign address ignored
        begin
          if (sh[23:16] == REG_LOWER)
          begin
            st_nxt.lowerWord = sh[15:0]; // held until upper word
          end
          else if (sh[23:16] == REG_UPPER)
          begin
            st_nxt.upperWord = sh[15:0];
            st_nxt.update    = 1'b1; // applied next cycle
            st_nxt.settle    = SETTLE_LEN;
            if (st_r.mode == MODE_16)
            begin
              st_nxt.pull = {sh[15:0], {LOWER_BITS{1'b0}}};
            end
            else
            begin
              st_nxt.pull = {sh[15:0], st_r.lowerWord[LOWER_BITS-1:0]};
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign pullValue  = st_r.pull;
  assign pullUpdate = st_r.update;
  assign settling   = st_r.settle != 12'h0;
  assign linkReady  = st_r.ready;

endmodule // tlw_device

/* tlw_host.sv */
`timescale 1ns/10ps
module tlw_host
  import tlw_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   psel,
  input  wire logic   penable,
  input  wire logic   pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  tlw_if.host_mp      link
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DRIVE = 2'b01,
    TX_MID   = 2'b10,
    TX_GAP   = 2'b11
  } tx_state_e;

  typedef struct packed {
    tx_state_e   state;
    logic [7:0]  timer;
    logic [5:0]  bitsLeft;
    logic [39:0] shift;
    logic        drive;
    logic [11:0] target;
    logic [15:0] data;
    logic        done;
    logic [31:0] rdata;
  } host_s;

  host_s st_r;
  host_s st_nxt;
  logic  apbWrite;
  logic  apbRead;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && !penable && !pwrite;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (apbRead)
    begin
      case (paddr)
        OFS_TARGET: st_nxt.rdata = {20'h0, st_r.target};
        OFS_DATA:   st_nxt.rdata = {16'h0, st_r.data};
        OFS_STATUS: st_nxt.rdata = {30'h0, st_r.done, st_r.state != TX_IDLE};
        default:    st_nxt.rdata = 32'h0;
      endcase
    end
    if (apbWrite)
    begin
      case (paddr)
        OFS_TARGET: st_nxt.target = pwdata[11:0];
        OFS_DATA:   st_nxt.data = pwdata[15:0];
        OFS_STATUS:
        begin
          if (pwdata[STAT_DONE_BIT])
          begin
            st_nxt.done = 1'b0;
          end
        end
        OFS_CTRL:
        begin
          if (pwdata[CTRL_GO_BIT] && st_r.state == TX_IDLE)
          begin
            // header, register address, word; msb first
            st_nxt.shift    = {HDR_HI, st_r.target[11:8], HDR_LO, st_r.target[7:0],
                               st_r.data};
            st_nxt.bitsLeft = 6'(FRAME_BITS);
            st_nxt.state    = TX_DRIVE;
            st_nxt.drive    = 1'b1;
            st_nxt.timer    = 8'(LOGIC_CYC - 1);
          end
        end
        default: st_nxt.done = st_nxt.done;
      endcase
    end
    case (st_r.state)
      TX_DRIVE:
      begin
        if (st_r.timer == 8'h0)
        begin
          st_nxt.state = TX_MID;
          st_nxt.drive = 1'b0; // release for mid level
          st_nxt.timer = 8'(MIDDLE_CYC - 1);
        end
        else
        begin
          st_nxt.timer = st_r.timer - 8'h1; // hold high or low
        end
      end
      TX_MID:
      begin
        if (st_r.timer != 8'h0)
        begin
          st_nxt.timer = st_r.timer - 8'h1;
        end
        else if (st_r.bitsLeft == 6'h1)
        begin
          st_nxt.state = TX_GAP;
          st_nxt.timer = 8'(GAP_CYC - 1);
        end
        else
        begin
          st_nxt.shift    = {st_r.shift[38:0], 1'b0};
          st_nxt.bitsLeft = st_r.bitsLeft - 6'h1;
          st_nxt.state    = TX_DRIVE;
          st_nxt.drive    = 1'b1;
          st_nxt.timer    = 8'(LOGIC_CYC - 1);
        end
      end
      TX_GAP:
      begin
        if (st_r.timer == 8'h0)
        begin
          st_nxt.state = TX_IDLE;
          st_nxt.done  = 1'b1; // set wins over a same-cycle clear
        end
        else
        begin
          st_nxt.timer = st_r.timer - 8'h1;
        end
      end
      default: st_nxt.drive = (st_nxt.state == TX_DRIVE); // keep drive if go just fired
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata         = st_r.rdata;
  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  assign link.pinOut    = st_r.shift[39]; // one high, zero low
  assign link.pinDriveN = !st_r.drive; // tri-state capable output

endmodule // tlw_host

/* tlw_if.sv */
`timescale 1ns/10ps
interface tlw_if;
  import tlw_pkg::*;

  logic   pinOut;
  logic   pinDriveN;
  level_e lineLevel;

  // released line sits at mid level through the resistor divider
  assign lineLevel = pinDriveN ? LVL_MID : (pinOut ? LVL_HIGH : LVL_LOW);

  modport host_mp (
    output pinOut,
    output pinDriveN
  );

  modport device_mp (
    input lineLevel
  );
endinterface

/* tlw_link_asserts.sv */
`timescale 1ns/10ps
module tlw_link_asserts
  import tlw_pkg::*;
(
  input logic   clk,
  input logic   sys_rst,
  input logic   pinOut,
  input logic   pinDriveN,
  input level_e lineLevel
);
  localparam int MAXM = GAP_CYC + MIDDLE_CYC;
  int          drvCnt;
  int          midCnt;
  int          bitCnt;
  logic [39:0] shReg;

  // ----------------------------------------
  // phase and bit counters seen on the wire
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      drvCnt <= 0;
      midCnt <= MAXM;
      bitCnt <= 0;
      shReg  <= '0;
    end
    else if (!pinDriveN)
    begin
      drvCnt <= drvCnt + 1;
      midCnt <= 0;
      if (midCnt != 0)
      begin
        bitCnt <= bitCnt + 1;
        shReg  <= {shReg[38:0], pinOut};
      end
    end
    else
    begin
      drvCnt <= 0;
      if (midCnt < MAXM)
        midCnt <= midCnt + 1;
      if (midCnt == MAXM - 1)
        bitCnt <= 0;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence bit_start;
    $fell(pinDriveN);
  endsequence

  sequence frame_end;
    pinDriveN && midCnt == MAXM - 1 && bitCnt != 0;
  endsequence

  chk_reset_release: assert property (disable iff (1'b0) sys_rst |=> pinDriveN)
    else $error("line not released after reset");
  chk_level_map: assert property (lineLevel == (pinDriveN ? LVL_MID
    : (pinOut ? LVL_HIGH : LVL_LOW))) else $error("line level wrong");
  chk_logic_width: assert property ($rose(pinDriveN) |-> drvCnt >= LOGIC_CYC)
    else $error("driven phase too short");
  chk_mid_width: assert property (bit_start |-> midCnt >= MIDDLE_CYC)
    else $error("mid phase too short");
  chk_bit_stable: assert property (!pinDriveN && !$past(pinDriveN)
    |-> $stable(pinOut)) else $error("bit value moved while driven");
  chk_frame_len: assert property (frame_end |-> bitCnt == FRAME_BITS)
    else $error("frame bit count wrong");
  chk_header_msb: assert property (frame_end |-> shReg[39:32] == HDR_HI
    && shReg[27:24] == HDR_LO) else $error("frame header wrong");
  chk_frame_gap: assert property (bit_start |-> bitCnt < FRAME_BITS)
    else $error("next frame too soon");
  chk_bit_rate: assert property ($fell(pinDriveN) && bitCnt != 0
    |-> midCnt == MIDDLE_CYC) else $error("bit period off rate");
endmodule // tlw_link_asserts

/* tlw_pkg.sv */
package tlw_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ    = 100;
  localparam int LOGIC_NS   = 500;
  localparam int MIDDLE_NS  = 500;
  localparam int GAP_NS     = 2000;
  localparam int SETTLE_US  = 30;
  localparam int POWERUP_US = 10;

  localparam int LOGIC_CYC   = (LOGIC_NS * CLK_MHZ + 999) / 1000;
  localparam int MIDDLE_CYC  = (MIDDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC     = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
  localparam int POWERUP_CYC = (POWERUP_US * CLK_MHZ);

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam int         FRAME_BITS = 40;
  localparam int         HDR_BITS   = 16;
  localparam logic [7:0] HDR_HI     = 8'hfa;
  localparam logic [3:0] HDR_LO     = 4'ha;
  localparam logic [7:0] REG_UPPER  = 8'h06;
  localparam logic [7:0] REG_LOWER  = 8'h07;
  localparam int         LOWER_BITS = 7;
  localparam int         PULL_W     = 23;

  // ------------------------------------------------------------------
  // line levels and modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_MID  = 2'b01,
    LVL_HIGH = 2'b10
  } level_e;

  typedef enum logic {
    MODE_16 = 1'b0,
    MODE_23 = 1'b1
  } pull_mode_e;

  // ------------------------------------------------------------------
  // host apb register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_TARGET    = 8'h00;
  localparam logic [7:0] OFS_DATA      = 8'h04;
  localparam logic [7:0] OFS_CTRL      = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam int         CTRL_GO_BIT   = 0;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_DONE_BIT = 1;

endpackage

/* tri_level_pull_word_link_tb_top.sv */
`timescale 1ns/10ps
module tri_level_pull_word_link_tb_top
  import tlw_pkg::*;
;
  logic              clk = 0;
  logic              sys_rst = 1;
  logic              psel = 0;
  logic              penable = 0;
  logic              pwrite = 0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [3:0]        devAddr = 4'h3;
  pull_mode_e        mode = MODE_16;
  logic [PULL_W-1:0] pullValue;
  logic              pullUpdate;
  logic              settling;
  logic              linkReady;
  int                errorCnt = 0;
  int                nCompared = 0;
  int                updCnt = 0;
  logic [31:0]       q;
  logic [22:0]       expP;
  logic [3:0]        dvT [5] = '{4'h3, 4'h3, 4'h5, 4'h3, 4'h3};
  logic [7:0]        rgT [5] = '{8'h06, 8'h06, 8'h06, 8'h07, 8'h05};
  logic [15:0]       dtT [5] = '{16'h099c, 16'h8001, 16'h1234, 16'h5555, 16'h7777};

  always #5 clk = ~clk;
  always @(posedge clk) if (pullUpdate === 1'b1) updCnt++;

  tlw_if link_if ();
  tlw_host tlw_host_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  tlw_device tlw_device_inst (.clk(clk), .sys_rst(sys_rst), .devAddrStrap(devAddr),
    .modeStrap(mode), .link(link_if), .pullValue(pullValue), .pullUpdate(pullUpdate),
    .settling(settling), .linkReady(linkReady));
  tlw_link_asserts tlw_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
    .pinOut(link_if.pinOut), .pinDriveN(link_if.pinDriveN), .lineLevel(link_if.lineLevel));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    chk("slverr", {31'h0, pslverr}, 32'h0);
    if (n >= 50)
    begin
      errorCnt++;
      end_sim();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic frame(input logic [3:0] dv, input logic [7:0] rg, input logic [15:0] dt);
    int n;
    n = 0;
    apb(1'b1, OFS_TARGET, {20'h0, dv, rg});
    apb(1'b1, OFS_DATA, {16'h0, dt});
    apb(1'b0, OFS_TARGET, 32'h0);
    chk("target", q, {20'h0, dv, rg});
    apb(1'b1, OFS_CTRL, 32'h1);
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (q[STAT_DONE_BIT] !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      errorCnt++;
      end_sim();
    end
    chk("busy", {31'h0, q[STAT_BUSY_BIT]}, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h2);
  endtask

  task automatic restart(input logic [3:0] dv, input pull_mode_e m);
    sys_rst <= 1'b1;
    devAddr <= dv;
    mode    <= m;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    #900000;
    errorCnt++;
    end_sim();
  end

  initial
  begin
    restart(4'h3, MODE_16);
    chk("ready", {31'h0, linkReady}, 32'h0);
    frame(4'h3, 8'h06, 16'h0000);
    chk("early", updCnt, 0);
    chk("ready", {31'h0, linkReady}, 32'h1);
    expP = '0;
    for (int i = 0; i < 5; i++)
    begin
      updCnt = 0;
      frame(dvT[i], rgT[i], dtT[i]);
      if (dvT[i] == 4'h3 && rgT[i] == REG_UPPER) expP = {dtT[i], 7'h0};
      chk("updates", updCnt, (expP == {dtT[i], 7'h0}) ? 1 : 0);
      chk("pull", {9'h0, pullValue}, {9'h0, expP});
    end
    restart(4'h0, MODE_23);
    repeat (POWERUP_CYC + 5) @(posedge clk);
    updCnt = 0;
    frame(4'h0, REG_LOWER, 16'h006a);
    chk("half", updCnt, 0);
    frame(4'h0, REG_UPPER, 16'hb67b);
    chk("updates", updCnt, 1);
    chk("pull", {9'h0, pullValue}, 32'h005b3dea);
    chk("settle", {31'h0, settling}, 32'h1);
    repeat (SETTLE_CYC) @(posedge clk);
    chk("settle", {31'h0, settling}, 32'h0);
    end_sim();
  end
endmodule // tri_level_pull_word_link_tb_top
